/* common/icsr_pkg.sv */
// Package with register map, field positions and carrier types of the interrupt control block.
package icsr_pkg;

  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int ADR_W = 8;
  localparam int SRC_PER_FLAG_REG = 16;
  localparam int SRC_PER_PRIO_REG = 4;
  localparam int PRIO_W = 3;
  localparam int LEVEL_W = 4;
  localparam int VEC_W = 7;
  localparam int NUM_PRIO_REGS = 20;
  localparam int MAX_FLAG_REGS = 5;
  localparam int NUM_EXT = 3;
  localparam int NUM_TRAP = 4;

  // Word indices; byte address is four times the index.
  localparam logic [5:0] IDX_CTRL1 = 6'h00;
  localparam logic [5:0] IDX_CTRL2 = 6'h01;
  localparam logic [5:0] IDX_STATUS = 6'h02;
  localparam logic [5:0] IDX_CORE = 6'h03;
  localparam logic [5:0] IDX_FLAG0 = 6'h04;
  localparam logic [5:0] IDX_EN0 = 6'h09;
  localparam logic [5:0] IDX_PRIO0 = 6'h10;

  // Priority registers that exist; the others read zero and ignore writes.
  localparam logic [NUM_PRIO_REGS-1:0] PRIO_IMPL = 20'h59FFF;

  localparam int CTRL1_NEST_BIT = 15;
  localparam int CTRL1_TRAP_LSB = 1;
  localparam int CTRL2_ALT_BIT = 15;
  localparam int CTRL2_TEMP_DISABLE_ACTIVE_BIT = 14;
  localparam int CTRL2_EP_LSB = 0;
  localparam int STATUS_LVL_LSB = 5;
  localparam int CORE_HIGH_BIT = 3;
  localparam int CORE_PSV_BIT = 2;

  // Source numbers of external interrupts 0, 1 and 2.
  localparam int EXT_SRC [NUM_EXT] = '{0, 20, 29};

  localparam logic [REG_W-1:0] REG_RESET = 16'h0000;
  localparam logic [LEVEL_W-1:0] LEVEL_RESET = 4'h0;

  typedef struct packed {
    logic valid;
    logic [VEC_W-1:0] vector;
    logic [PRIO_W-1:0] level;
  } icsr_irq_t;

endpackage : icsr_pkg

/* hw/icsr_top.sv */
// Interrupt control and status registers with a classic Wishbone slave and source arbitration.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/100ps
module icsr_top
  import icsr_pkg::*;
#(
  parameter int NUM_FLAG_REGS = MAX_FLAG_REGS
) (
  input wire logic clk_i, // System clock, 100 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic [ADR_W-1:0] wb_adr_i, // Wishbone byte address.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic [DATA_W-1:0] wb_dat_i, // Wishbone write data.
  output logic [DATA_W-1:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic [16*NUM_FLAG_REGS-1:0] src_set_i, // Peripheral request pulses, one per source.
  input wire logic [NUM_EXT-1:0] ext_irq_i, // External interrupt pins 2..0.
  input wire logic [NUM_TRAP-1:0] trap_set_i, // Trap events: arith, addr, stack, osc (3..0).
  input wire logic level_load_i, // Core loads a new CPU level.
  input wire logic [LEVEL_W-1:0] level_value_i, // CPU level loaded by the core.
  input wire logic in_service_i, // Core is running a handler.
  input wire logic temp_disable_i, // Temporary disable instruction in effect.
  output icsr_irq_t irq_o, // Winning request towards the core.
  output logic alt_table_o, // Use the alternate vector table.
  output logic [LEVEL_W-1:0] cpu_level_o // Current four-bit CPU level.
);

  localparam int NUM_SRC = SRC_PER_FLAG_REG * NUM_FLAG_REGS;

  if (NUM_FLAG_REGS < 2 || NUM_FLAG_REGS > MAX_FLAG_REGS) begin : g_check
    $error("NUM_FLAG_REGS must lie between 2 and 5");
  end

  logic ack_reg;
  logic [DATA_W-1:0] dat_reg;
  logic [NUM_SRC-1:0] flag_reg;
  logic [NUM_SRC-1:0] flag_next;
  logic [NUM_SRC-1:0] enable_reg;
  logic [NUM_SRC-1:0][PRIO_W-1:0] prio_reg;
  logic nest_reg;
  logic [NUM_TRAP-1:0] trap_reg;
  logic alt_reg;
  logic temp_disable_active_reg;
  logic [NUM_EXT-1:0] edge_pol_reg;
  logic [LEVEL_W-1:0] level_reg;
  logic psv_reg;
  logic [NUM_EXT-1:0] sync1_reg;
  logic [NUM_EXT-1:0] sync2_reg;
  logic [NUM_EXT-1:0] prev_reg;
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_SRC-1:0] ext_set;
  icsr_irq_t irq_reg;
  icsr_irq_t irq_next;

  logic [5:0] idx;
  logic req;
  logic wr_fire;
  logic [REG_W-1:0] rd_val;
  logic [REG_W-1:0] wr_val;

  assign idx = wb_adr_i[7:2];
  assign req = wb_cyc_i & wb_stb_i;
  // The write lands on the edge at which the master sees ack high.
  assign wr_fire = req & wb_we_i & ack_reg;

  // Byte lanes 0 and 1 carry the 16-bit register; the upper lanes are ignored.
  always_comb begin
    wr_val = rd_val;
    if (wb_sel_i[0]) begin
      wr_val[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wr_val[15:8] = wb_dat_i[15:8];
    end
  end

  // Read mux; every bit not assigned here reads zero.
  always_comb begin
    rd_val = REG_RESET;
    if (idx == IDX_CTRL1) begin
      rd_val[CTRL1_NEST_BIT] = nest_reg;
      rd_val[CTRL1_TRAP_LSB +: NUM_TRAP] = trap_reg;
    end else if (idx == IDX_CTRL2) begin
      rd_val[CTRL2_ALT_BIT] = alt_reg;
      rd_val[CTRL2_TEMP_DISABLE_ACTIVE_BIT] = temp_disable_active_reg;
      rd_val[CTRL2_EP_LSB +: NUM_EXT] = edge_pol_reg;
    end else if (idx == IDX_STATUS) begin
      rd_val[STATUS_LVL_LSB +: PRIO_W] = level_reg[PRIO_W-1:0];
    end else if (idx == IDX_CORE) begin
      rd_val[CORE_HIGH_BIT] = level_reg[LEVEL_W-1];
      rd_val[CORE_PSV_BIT] = psv_reg;
    end
    for (int r = 0; r < NUM_FLAG_REGS; r++) begin
      if (idx == IDX_FLAG0 + 6'(r)) begin
        rd_val = flag_reg[r*SRC_PER_FLAG_REG +: SRC_PER_FLAG_REG];
      end
      if (idx == IDX_EN0 + 6'(r)) begin
        rd_val = enable_reg[r*SRC_PER_FLAG_REG +: SRC_PER_FLAG_REG];
      end
    end
    for (int p = 0; p < NUM_PRIO_REGS; p++) begin
      if (idx == IDX_PRIO0 + 6'(p) && PRIO_IMPL[p]) begin
        for (int n = 0; n < SRC_PER_PRIO_REG; n++) begin
          if (p * SRC_PER_PRIO_REG + n < NUM_SRC) begin
            rd_val[n*4 +: PRIO_W] = prio_reg[p*SRC_PER_PRIO_REG + n];
          end
        end
      end
    end
  end

  // Wishbone answer: ack one cycle after the request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= '0;
    end else begin
      ack_reg <= req & ~ack_reg;
      dat_reg <= {{(DATA_W-REG_W){1'b0}}, rd_val};
    end
  end

  // External pins: two-stage synchroniser, then edge of the selected polarity.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= ext_irq_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  always_comb begin
    ext_set = '0;
    for (int e = 0; e < NUM_EXT; e++) begin
      ext_edge[e] = edge_pol_reg[e] ? (prev_reg[e] & ~sync2_reg[e]) : (~prev_reg[e] & sync2_reg[e]);
      ext_set[EXT_SRC[e]] = ext_edge[e];
    end
  end

  // A hardware set in the same cycle as a software clear wins.
  always_comb begin
    flag_next = flag_reg;
    for (int r = 0; r < NUM_FLAG_REGS; r++) begin
      if (wr_fire && idx == IDX_FLAG0 + 6'(r)) begin
        flag_next[r*SRC_PER_FLAG_REG +: SRC_PER_FLAG_REG] = wr_val;
      end
    end
    flag_next = flag_next | src_set_i | ext_set;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_reg <= '0;
    end else begin
      for (int r = 0; r < NUM_FLAG_REGS; r++) begin
        if (wr_fire && idx == IDX_EN0 + 6'(r)) begin
          enable_reg[r*SRC_PER_FLAG_REG +: SRC_PER_FLAG_REG] <= wr_val;
        end
      end
    end
  end

  // Sources mapped to absent priority registers keep level zero and never win.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio_reg <= '0;
    end else begin
      for (int p = 0; p < NUM_PRIO_REGS; p++) begin
        if (wr_fire && idx == IDX_PRIO0 + 6'(p) && PRIO_IMPL[p]) begin
          for (int n = 0; n < SRC_PER_PRIO_REG; n++) begin
            if (p * SRC_PER_PRIO_REG + n < NUM_SRC) begin
              prio_reg[p*SRC_PER_PRIO_REG + n] <= wr_val[n*4 +: PRIO_W];
            end
          end
        end
      end
    end
  end

  // Control one: nesting disable and trap flags; a trap beats a same-cycle clear.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nest_reg <= 1'b0;
      trap_reg <= '0;
    end else begin
      if (wr_fire && idx == IDX_CTRL1) begin
        nest_reg <= wr_val[CTRL1_NEST_BIT];
        trap_reg <= wr_val[CTRL1_TRAP_LSB +: NUM_TRAP] | trap_set_i;
      end else begin
        trap_reg <= trap_reg | trap_set_i;
      end
    end
  end

  // Control two: table select, edge polarities and the registered disable status.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alt_reg <= 1'b0;
      edge_pol_reg <= '0;
      temp_disable_active_reg <= 1'b0;
    end else begin
      temp_disable_active_reg <= temp_disable_i;
      if (wr_fire && idx == IDX_CTRL2) begin
        alt_reg <= wr_val[CTRL2_ALT_BIT];
        edge_pol_reg <= wr_val[CTRL2_EP_LSB +: NUM_EXT];
      end
    end
  end

  // CPU level: the core's own load takes precedence over any software write.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      level_reg <= LEVEL_RESET;
      psv_reg <= 1'b0;
    end else begin
      if (wr_fire && idx == IDX_CORE) begin
        psv_reg <= wr_val[CORE_PSV_BIT];
      end
      if (level_load_i) begin
        level_reg <= level_value_i;
      end else if (wr_fire && idx == IDX_STATUS && !nest_reg) begin
        level_reg[PRIO_W-1:0] <= wr_val[STATUS_LVL_LSB +: PRIO_W];
      end else if (wr_fire && idx == IDX_CORE && !wr_val[CORE_HIGH_BIT]) begin
        level_reg[LEVEL_W-1] <= 1'b0;
      end
    end
  end

  // Scanning downward with >= lets the lowest vector win a priority tie.
  always_comb begin
    irq_next = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (flag_reg[i] && enable_reg[i] && {1'b0, prio_reg[i]} > level_reg &&
          (!irq_next.valid || prio_reg[i] >= irq_next.level)) begin
        irq_next.valid = 1'b1;
        irq_next.vector = VEC_W'(i);
        irq_next.level = prio_reg[i];
      end
    end
    if (nest_reg && in_service_i) begin
      irq_next = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o = irq_reg;
  assign alt_table_o = alt_reg;
  assign cpu_level_o = level_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_high_bit_blocked: assert property (
    (wr_fire && idx == IDX_CORE && !level_load_i && !level_reg[LEVEL_W-1]) |=> !level_reg[LEVEL_W-1])
    else $error("software set the high CPU level bit");

  a_nest_locks_level: assert property (
    (wr_fire && idx == IDX_STATUS && nest_reg && !level_load_i) |=> $stable(level_reg))
    else $error("CPU level changed while nesting disabled");

  a_flag_set_wins: assert property (
    1'b1 |=> ((flag_reg & $past(src_set_i)) == $past(src_set_i)))
    else $error("request pulse lost");

  a_level7_blocks: assert property (
    (level_reg[PRIO_W-1:0] == 3'h7) |=> !irq_reg.valid)
    else $error("request presented at CPU level seven");

  a_irq_above_level: assert property (
    irq_reg.valid |-> ({1'b0, irq_reg.level} > $past(level_reg)) && $past(flag_reg[irq_next.vector]))
    else $error("request not above CPU level");

  a_nest_no_preempt: assert property (
    (nest_reg && in_service_i) |=> !irq_reg.valid)
    else $error("handler preempted with nesting disabled");

  a_ext_edge_flag: assert property (
    ext_edge[0] |=> flag_reg[EXT_SRC[0]])
    else $error("external edge did not set its flag");

  a_trap_flag_set: assert property (
    trap_set_i[0] |=> trap_reg[0] ##1 (trap_reg[0] || $past(wr_fire)))
    else $error("trap flag not set");

  a_temp_disable_active_tracks: assert property (
    1'b1 |=> (temp_disable_active_reg == $past(temp_disable_i)))
    else $error("disable status does not follow the core");

  a_ack_single_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge held for more than one cycle");

  a_enable_gates: assert property (
    irq_reg.valid |-> $past(enable_reg[irq_next.vector]))
    else $error("disabled source presented");

  a_alt_follows_write: assert property (
    (wr_fire && idx == IDX_CTRL2) |=> (alt_table_o == $past(wr_val[CTRL2_ALT_BIT])))
    else $error("table select does not follow the write");

endmodule : icsr_top

/* verification/icsr_core_model.sv */
// Processor core model that takes the winning request and loads its level.
`timescale 1ns/100ps
module icsr_core_model
  import icsr_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire icsr_irq_t irq_i, // Winning request from the controller.
  input wire logic take_i, // Core may accept a request.
  input wire logic high_i, // Enter the handler at a trap level.
  input wire logic leave_i, // Handler returns.
  output logic load_o, // Level load strobe.
  output logic [LEVEL_W-1:0] level_o, // Level to load.
  output logic busy_o // Handler is running.
);
  // The core never clears a flag; the handler has to write zero itself.
  always_ff @(posedge clk_i) begin
    load_o <= 1'h0;
    if (rst_i) begin
      busy_o <= 1'h0;
      level_o <= LEVEL_RESET;
    end else if (leave_i && busy_o) begin
      busy_o <= 1'h0;
      load_o <= 1'h1;
      level_o <= LEVEL_RESET;
    end else if (take_i && irq_i.valid && !busy_o) begin
      busy_o <= 1'h1;
      load_o <= 1'h1;
      level_o <= {high_i, irq_i.level};
    end
  end
endmodule : icsr_core_model

/* verification/interrupt_control_status_regs_test.sv */
// Self-checking bench for the interrupt control and status registers.
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module interrupt_control_status_regs_test
  import icsr_pkg::*;
;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic req = 1'h0;
  logic we = 1'h0;
  logic [3:0] sel = 4'h0;
  logic [ADR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wdat = '0;
  logic [DATA_W-1:0] rdat;
  logic ack, alt, load, busy;
  logic take = 1'h0, high = 1'h0, leave = 1'h0, tdis = 1'h0;
  logic [79:0] src = '0;
  logic [2:0] ext = '0;
  logic [3:0] trap = '0;
  logic [LEVEL_W-1:0] lvl, cpu_lvl;
  icsr_irq_t irq;
  logic [15:0] q;
  logic [63:0] pr;
  logic [5:0] fidx;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n, m, pn, pm, s;
  logic [5:0] t_idx [9] = '{IDX_STATUS, IDX_CTRL1, IDX_CTRL2, IDX_CORE, IDX_EN0, IDX_EN0, IDX_PRIO0, 6'h1D, 6'h3F};
  logic [3:0] t_sel [9] = '{4'h3, 4'h3, 4'h3, 4'h3, 4'h1, 4'h2, 4'h3, 4'h3, 4'h3};
  logic [15:0] t_exp [9] = '{16'h00E0, 16'h801E, 16'h8007, 16'h0004, 16'h00FF, 16'hFFFF, 16'h7777, 16'h0, 16'h0};

  icsr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .src_set_i(src), .ext_irq_i(ext),
    .trap_set_i(trap), .level_load_i(load), .level_value_i(lvl), .in_service_i(busy), .temp_disable_i(tdis),
    .irq_o(irq), .alt_table_o(alt), .cpu_level_o(cpu_lvl));
  icsr_core_model CORE (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq), .take_i(take), .high_i(high),
    .leave_i(leave), .load_o(load), .level_o(lvl), .busy_o(busy));

  always #5 clk_i = ~clk_i;

  // A hung handshake must still reach the verdict, so the whole run is capped.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  function automatic logic [15:0] bit_of(int b);
    return 16'h1 << b;
  endfunction : bit_of

  function automatic icsr_irq_t win(int a, int b, int pa, int pb);
    win.valid = 1'h1;
    win.vector = VEC_W'((pb > pa) ? b : a);
    win.level = PRIO_W'((pb > pa) ? pb : pa);
  endfunction : win

  task automatic tick(int k);
    repeat (k) @(posedge clk_i);
  endtask : tick

  task automatic wb(logic w, logic [5:0] i, logic [3:0] bs, logic [15:0] d);
    int c;
    c = 0;
    @(posedge clk_i);
    req <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    sel <= bs;
    wdat <= {16'h0, d};
    do begin
      @(posedge clk_i);
      c++;
    end while (ack !== 1'h1 && c < 20);
    `CHK(ack, 1'h1)
    `CHK(rdat[31:16], 16'h0000)
    q = rdat[15:0];
    req <= 1'h0;
    we <= 1'h0;
  endtask : wb

  task automatic rchk(logic [5:0] i, logic [15:0] e);
    wb(1'h0, i, 4'h3, '0);
    `CHK(q, e)
  endtask : rchk

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    void'($urandom(32'h637C));
    tick(3);
    rst_i <= 1'h0;
    for (int i = 0; i < 9; i++) rchk(t_idx[i], '0);
    for (int i = 0; i < 9; i++) begin
      wb(1'h1, t_idx[i], t_sel[i], 16'hFFFF);
      rchk(t_idx[i], t_exp[i]);
    end
    `CHK(alt, 1'h1)
    `CHK(cpu_lvl, 4'h7)
    wb(1'h1, IDX_CTRL1, 4'h3, '0);
    for (int i = 0; i < 9; i++) wb(1'h1, t_idx[i], 4'h3, '0);
    `CHK(alt, 1'h0)
    tdis <= 1'h1;
    tick(2);
    rchk(IDX_CTRL2, 16'h4000);
    tdis <= 1'h0;
    for (int k = 0; k < NUM_TRAP; k++) begin
      trap <= 4'(4'h1 << k);
      tick(1);
      trap <= '0;
      rchk(IDX_CTRL1, bit_of(k + CTRL1_TRAP_LSB));
      wb(1'h1, IDX_CTRL1, 4'h3, '0);
    end
    $display("Register and trap tests done");
    for (int it = 0; it < 8; it++) begin
      n = $urandom_range(0, 14);
      m = $urandom_range(n + 1, 15);
      pn = $urandom_range(1, 6);
      pm = pn + it % 2;
      pr = '0;
      pr[4*n +: 3] = 3'(pn);
      pr[4*m +: 3] = 3'(pm);
      for (int r = 0; r < 4; r++) wb(1'h1, 6'(IDX_PRIO0 + r), 4'h3, pr[16*r +: 16]);
      wb(1'h1, IDX_EN0, 4'h3, bit_of(n) | bit_of(m));
      src[n] <= 1'h1;
      src[m] <= 1'h1;
      tick(1);
      src <= '0;
      tick(4);
      `CHK(irq, win(n, m, pn, pm))
      rchk(IDX_FLAG0, bit_of(n) | bit_of(m));
      wb(1'h1, IDX_STATUS, 4'h3, 16'(pm) << STATUS_LVL_LSB);
      tick(4);
      `CHK(irq.valid, 1'h0)
      wb(1'h1, IDX_STATUS, 4'h3, '0);
      wb(1'h1, IDX_FLAG0, 4'h3, '0);
      wb(1'h1, IDX_EN0, 4'h3, '0);
    end
    $display("Arbitration tests done");
    wb(1'h1, IDX_CTRL1, 4'h3, 16'h8000);
    wb(1'h1, IDX_PRIO0, 4'h3, 16'h0530);
    wb(1'h1, IDX_EN0, 4'h3, 16'h0006);
    take <= 1'h1;
    src[1] <= 1'h1;
    tick(1);
    src <= '0;
    tick(6);
    take <= 1'h0;
    `CHK(cpu_lvl, 4'h3)
    src[2] <= 1'h1;
    tick(1);
    src <= '0;
    tick(5);
    `CHK(irq.valid, 1'h0)
    wb(1'h1, IDX_STATUS, 4'h3, 16'h00E0);
    rchk(IDX_STATUS, 16'h0060);
    wb(1'h1, IDX_CTRL1, 4'h3, '0);
    tick(4);
    `CHK(irq, win(2, 2, 5, 5))
    leave <= 1'h1;
    tick(2);
    leave <= 1'h0;
    high <= 1'h1;
    take <= 1'h1;
    tick(4);
    take <= 1'h0;
    high <= 1'h0;
    rchk(IDX_CORE, 16'h0008);
    `CHK(cpu_lvl, 4'hD)
    `CHK(irq.valid, 1'h0)
    wb(1'h1, IDX_CORE, 4'h3, '0);
    rchk(IDX_CORE, '0);
    leave <= 1'h1;
    tick(2);
    leave <= 1'h0;
    wb(1'h1, IDX_EN0, 4'h3, '0);
    tick(4);
    `CHK(irq.valid, 1'h0)
    wb(1'h1, IDX_FLAG0, 4'h3, '0);
    $display("Nesting and level tests done");
    for (int e = 0; e < NUM_EXT; e++) begin
      for (int p = 0; p < 2; p++) begin
        s = EXT_SRC[e];
        fidx = 6'(IDX_FLAG0 + s / 16);
        wb(1'h1, IDX_CTRL2, 4'h3, 16'(p) << e);
        ext[e] <= p[0];
        tick(6);
        wb(1'h1, fidx, 4'h3, '0);
        ext[e] <= ~p[0];
        tick(6);
        rchk(fidx, bit_of(s % 16));
        wb(1'h1, fidx, 4'h3, '0);
        ext[e] <= p[0];
        tick(6);
        rchk(fidx, '0);
      end
    end
    $display("External pin tests done");
    print_verdict();
  end
endmodule : interrupt_control_status_regs_test
